// >>> dmb_pkg.sv
// Purpose: constants and decoders for the mode register and burst order block
// Assumes: command pins and the link clock are sampled by clk at 100 MHz
// Notes: offsets are byte addresses on the AXI4-Lite register port
// What this block does
// - cas latency comes from mode bits A2 and A4-A6, counted in clock cycles
// - only whole-cycle latencies exist; undefined latency codes are not accepted
// - read data starts additive latency plus cas latency cycles after the read
// - bit A3 low picks sequential order, high picks interleaved order
// - burst length from A0-A1: fixed chop-4, fixed 8, or chosen per command
// - sequential 8-beat reads wrap low two bits within nibble, then other nibble
// - interleaved reads put beat i at start column xor i
// - chop-4 reads send four beats, then float data and strobe drivers
// - 8-beat writes store columns 0-7; chop-4 writes use only A2 for the half
// - fixed chop-4 pulls the write recovery reference two clocks earlier
// - dll reset bit clears itself once the reset has been performed
// - write recovery field A9-A11 plus precharge time gives auto-precharge delay
// - A12 low freezes the dll in precharge power-down, slow exit
// - A12 high keeps the dll running in precharge power-down, fast exit
// - mode set with BA0 high, BA1 and BA2 low loads the second mode register
// - mode set with all bank bits low loads the first mode register
package dmb_pkg;
    localparam logic [7:0] ADDR_MR0 = 8'h00;
    localparam logic [7:0] ADDR_MR1 = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DLLCYC = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam int ADDR_W = 14;
    localparam int BT_POS = 3;
    localparam int TM_POS = 7;
    localparam int DLLRST_POS = 8;
    localparam int PD_POS = 12;
    localparam int OTF_POS = 12;
    localparam int QOFF_POS = 12;
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam logic [13:0] MR_RESET = 14'h0000;
    localparam logic [15:0] DLLCYC_RESET = 16'h0200;
    localparam logic [4:0] CL_RESET = 5'h05;
    localparam logic [4:0] CWL_CYC = 5'h05;
    localparam logic [5:0] RP_CYC = 6'h0B;
    localparam logic [4:0] BURST_CK = 5'h04;
    localparam logic [4:0] BC4_PULL = 5'h02;
    // code is {A6,A5,A4,A2}; zero marks a reserved code
    function automatic logic [4:0] clDecode(input logic [3:0] code);
        logic [4:0] v;
        v = 5'h00;
        if (!code[0] && code[3:1] != 3'h0) begin
            v = 5'(code[3:1]) + 5'h04;
        end else if (code[0] && code[3:1] <= 3'h2) begin
            v = 5'(code[3:1]) + 5'h0C;
        end
        return v;
    endfunction
    function automatic logic [4:0] wrDecode(input logic [2:0] code);
        logic [4:0] v;
        v = 5'h10;
        if (code != 3'h0 && code <= 3'h4) begin
            v = 5'(code) + 5'h04;
        end else if (code > 3'h4) begin
            v = 5'({code, 1'b0}) - 5'h00;
        end
        return v;
    endfunction
endpackage

// >>> dmb_order_if.sv
`timescale 1ns/1ns
// Purpose: carries one beat lookup between an engine and the order calculator
// Assumes: purely combinational lookup
// Notes: one instance per engine
interface dmb_order_if;
    logic [2:0] startCol;
    logic [2:0] beatIdx;
    logic interleave;
    logic isWrite;
    logic chop;
    logic [2:0] col;
    modport user (output startCol, beatIdx, interleave, isWrite, chop, input col);
    modport calc (input startCol, beatIdx, interleave, isWrite, chop, output col);
endinterface

// >>> dmb_pin_sync.sv
`timescale 1ns/1ns
// Purpose: three-stage synchroniser for pins from outside the clk domain
// Assumes: inputs are asynchronous to clk
// Notes: stage one is read only by stage two
module dmb_pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] midQ,
    output logic [W-1:0] lastQ
);
    logic [W-1:0] firstQ;
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    firstQ[gi] <= 1'b0;
                    midQ[gi] <= 1'b0;
                    lastQ[gi] <= 1'b0;
                end else begin
                    firstQ[gi] <= pinIn[gi];
                    midQ[gi] <= firstQ[gi];
                    lastQ[gi] <= midQ[gi];
                end
            end
        end
    endgenerate
endmodule

// >>> dmb_burst_order.sv
`timescale 1ns/1ns
// Purpose: column of one beat within a burst
// Assumes: beat index 0..7
// Notes: chop-4 beats 4-7 still get a column; callers blank them
module dmb_burst_order (
    dmb_order_if.calc ord
);
    always_comb begin
        if (ord.isWrite) begin
            if (ord.chop) begin
                ord.col = {ord.startCol[2], ord.beatIdx[1:0]};
            end else begin
                ord.col = ord.beatIdx;
            end
        end else if (ord.interleave) begin
            ord.col = ord.startCol ^ ord.beatIdx;
        end else begin
            ord.col = {ord.startCol[2] ^ ord.beatIdx[2],
                       2'(ord.startCol[1:0] + ord.beatIdx[1:0])};
        end
    end
endmodule

// >>> dmb_mode_burst.sv
`timescale 1ns/1ns
// Purpose: mode register decode, read and write burst sequencing
// Assumes: link clock well below clk/4, sampled and edge detected here
// Notes: one read and one write tracked at a time; a second is ignored
module dmb_mode_burst (
    input wire logic clk,
    input wire logic rst,
    input wire logic ckPin,
    input wire logic ckeIn,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [2:0] baIn,
    input wire logic [13:0] addrIn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] rdColOut,
    output logic rdBeatValid,
    output logic dqOe,
    output logic dqsOe,
    output logic [2:0] wrColOut,
    output logic wrBeatValid,
    output logic wrRefPulse,
    output logic [5:0] dalCycles,
    output logic dllLocking,
    output logic dllFrozen,
    output logic testMode
);
    localparam int SW = 23;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_BURST = 2'b10
    } dmb_burst_e;
    logic [SW-1:0] pinMid;
    logic [SW-1:0] pinLast;
    logic ckLvl_reg;
    logic ckRise;
    logic ckFall;
    logic cmdSel;
    logic cmdMrs;
    logic cmdRead;
    logic cmdWrite;
    logic ckeSync;
    logic [2:0] baSync;
    logic [13:0] aSync;
    logic [13:0] mr0_reg;
    logic [13:0] mr1_reg;
    logic [4:0] cl_reg;
    logic [4:0] alVal;
    logic [4:0] rl;
    logic [4:0] wl;
    logic [15:0] dllCyc_reg;
    logic [15:0] dllCnt_reg;
    logic pd_reg;
    dmb_burst_e rdState_reg;
    logic [4:0] rdCnt_reg;
    logic [2:0] rdIdx_reg;
    logic [2:0] rdStart_reg;
    logic rdChop_reg;
    dmb_burst_e wrState_reg;
    logic [4:0] wrCnt_reg;
    logic [2:0] wrIdx_reg;
    logic [2:0] wrStart_reg;
    logic wrChop_reg;
    logic refArm_reg;
    logic [4:0] refCnt_reg;
    logic [4:0] refAt_reg;
    logic cmdChop;
    logic wrEn;
    logic [31:0] statusWord;

    dmb_pin_sync #(.W(SW)) u_sync (
        .clk(clk),
        .rst(rst),
        .pinIn({ckPin, ckeIn, csN, rasN, casN, weN, baIn, addrIn}),
        .midQ(pinMid),
        .lastQ(pinLast)
    );

    // a clock level counts only once two stages agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ckLvl_reg <= 1'b0;
        end else if (pinMid[SW-1] == pinLast[SW-1]) begin
            ckLvl_reg <= pinLast[SW-1];
        end
    end
    assign ckRise = !ckLvl_reg && pinMid[SW-1] && pinLast[SW-1];
    assign ckFall = ckLvl_reg && !pinMid[SW-1] && !pinLast[SW-1];
    assign ckeSync = pinLast[SW-2];
    assign baSync = pinLast[16:14];
    assign aSync = pinLast[13:0];
    assign cmdSel = ckRise && ckeSync && !pinLast[20];
    assign cmdMrs = cmdSel && !pinLast[19] && !pinLast[18] && !pinLast[17];
    assign cmdRead = cmdSel && pinLast[19] && !pinLast[18] && pinLast[17];
    assign cmdWrite = cmdSel && pinLast[19] && !pinLast[18] && !pinLast[17];
    // chop chosen per command only in on-the-fly mode
    assign cmdChop = (mr0_reg[1:0] == dmb_pkg::BL_OTF) ? !aSync[dmb_pkg::OTF_POS] :
                     (mr0_reg[1:0] == dmb_pkg::BL_FIX4);

    // mode registers; dll reset bit cleared by hardware, a new set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mr0_reg <= dmb_pkg::MR_RESET;
        end else if (cmdMrs && baSync == 3'h0) begin
            mr0_reg <= aSync;
        end else if (dllCnt_reg == 16'h0001) begin
            mr0_reg[dmb_pkg::DLLRST_POS] <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mr1_reg <= dmb_pkg::MR_RESET;
        end else if (cmdMrs && baSync == 3'h1) begin
            mr1_reg <= aSync;
        end
    end
    // reserved latency codes keep the previous setting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cl_reg <= dmb_pkg::CL_RESET;
        end else if (cmdMrs && baSync == 3'h0 &&
                     dmb_pkg::clDecode({aSync[6:4], aSync[2]}) != 5'h00) begin
            cl_reg <= dmb_pkg::clDecode({aSync[6:4], aSync[2]});
        end
    end
    always_comb begin
        case (mr1_reg[4:3])
            2'h1: alVal = cl_reg - 5'h01;
            2'h2: alVal = cl_reg - 5'h02;
            default: alVal = 5'h00;
        endcase
    end
    assign rl = alVal + cl_reg;
    assign wl = alVal + dmb_pkg::CWL_CYC;

    // dll reset runs for a software set number of clk cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dllCnt_reg <= 16'h0000;
        end else if (cmdMrs && baSync == 3'h0 && aSync[dmb_pkg::DLLRST_POS]) begin
            dllCnt_reg <= (dllCyc_reg == 16'h0000) ? 16'h0001 : dllCyc_reg;
        end else if (dllCnt_reg != 16'h0000) begin
            dllCnt_reg <= dllCnt_reg - 16'h0001;
        end
    end
    assign dllLocking = mr0_reg[dmb_pkg::DLLRST_POS];

    // precharge power-down entered when cke low with both engines idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_reg <= 1'b0;
        end else if (ckRise) begin
            pd_reg <= !ckeSync && rdState_reg == ST_IDLE && wrState_reg == ST_IDLE;
        end
    end
    assign dllFrozen = pd_reg && !mr0_reg[dmb_pkg::PD_POS];
    assign testMode = mr0_reg[dmb_pkg::TM_POS];
    assign dalCycles = 6'(dmb_pkg::wrDecode(mr0_reg[11:9])) + dmb_pkg::RP_CYC;

    // read engine: latency counted on link rises, beats on both edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdState_reg <= ST_IDLE;
            rdCnt_reg <= 5'h00;
            rdIdx_reg <= 3'h0;
            rdStart_reg <= 3'h0;
            rdChop_reg <= 1'b0;
        end else begin
            case (rdState_reg)
                ST_IDLE: begin
                    if (cmdRead) begin
                        rdState_reg <= ST_WAIT;
                        rdCnt_reg <= 5'h00;
                        rdStart_reg <= aSync[2:0];
                        rdChop_reg <= cmdChop;
                    end
                end
                ST_WAIT: begin
                    if (ckRise) begin
                        if (rdCnt_reg + 5'h01 >= rl) begin
                            rdState_reg <= ST_BURST;
                            rdIdx_reg <= 3'h0;
                        end else begin
                            rdCnt_reg <= rdCnt_reg + 5'h01;
                        end
                    end
                end
                ST_BURST: begin
                    if (ckRise || ckFall) begin
                        rdIdx_reg <= rdIdx_reg + 3'h1;
                        if (rdIdx_reg == 3'h7) begin
                            rdState_reg <= ST_IDLE;
                        end
                    end
                end
                default: rdState_reg <= ST_IDLE;
            endcase
        end
    end

    dmb_order_if rdOrd();
    assign rdOrd.startCol = rdStart_reg;
    assign rdOrd.beatIdx = rdIdx_reg;
    assign rdOrd.interleave = mr0_reg[dmb_pkg::BT_POS];
    assign rdOrd.isWrite = 1'b0;
    assign rdOrd.chop = rdChop_reg;
    dmb_burst_order u_rdOrd (
        .ord(rdOrd.calc)
    );

    // output disable also floats the drivers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdColOut <= 3'h0;
            rdBeatValid <= 1'b0;
            dqOe <= 1'b0;
            dqsOe <= 1'b0;
        end else begin
            rdColOut <= rdOrd.col;
            rdBeatValid <= rdState_reg == ST_BURST && !(rdChop_reg && rdIdx_reg[2]);
            dqOe <= rdState_reg == ST_BURST && !(rdChop_reg && rdIdx_reg[2]) &&
                    !mr1_reg[dmb_pkg::QOFF_POS];
            dqsOe <= rdState_reg == ST_BURST && !(rdChop_reg && rdIdx_reg[2]) &&
                     !mr1_reg[dmb_pkg::QOFF_POS];
        end
    end

    // write engine mirrors the read engine on the write latency
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrState_reg <= ST_IDLE;
            wrCnt_reg <= 5'h00;
            wrIdx_reg <= 3'h0;
            wrStart_reg <= 3'h0;
            wrChop_reg <= 1'b0;
        end else begin
            case (wrState_reg)
                ST_IDLE: begin
                    if (cmdWrite) begin
                        wrState_reg <= ST_WAIT;
                        wrCnt_reg <= 5'h00;
                        wrStart_reg <= aSync[2:0];
                        wrChop_reg <= cmdChop;
                    end
                end
                ST_WAIT: begin
                    if (ckRise) begin
                        if (wrCnt_reg + 5'h01 >= wl) begin
                            wrState_reg <= ST_BURST;
                            wrIdx_reg <= 3'h0;
                        end else begin
                            wrCnt_reg <= wrCnt_reg + 5'h01;
                        end
                    end
                end
                ST_BURST: begin
                    if (ckRise || ckFall) begin
                        wrIdx_reg <= wrIdx_reg + 3'h1;
                        if (wrIdx_reg == 3'h7) begin
                            wrState_reg <= ST_IDLE;
                        end
                    end
                end
                default: wrState_reg <= ST_IDLE;
            endcase
        end
    end

    dmb_order_if wrOrd();
    assign wrOrd.startCol = wrStart_reg;
    assign wrOrd.beatIdx = wrIdx_reg;
    assign wrOrd.interleave = mr0_reg[dmb_pkg::BT_POS];
    assign wrOrd.isWrite = 1'b1;
    assign wrOrd.chop = wrChop_reg;
    dmb_burst_order u_wrOrd (
        .ord(wrOrd.calc)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrColOut <= 3'h0;
            wrBeatValid <= 1'b0;
        end else begin
            wrColOut <= wrOrd.col;
            wrBeatValid <= wrState_reg == ST_BURST && !(wrChop_reg && wrIdx_reg[2]);
        end
    end

    // recovery reference: end of burst, two clocks sooner for fixed chop-4
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refArm_reg <= 1'b0;
            refCnt_reg <= 5'h00;
            refAt_reg <= 5'h00;
            wrRefPulse <= 1'b0;
        end else begin
            wrRefPulse <= 1'b0;
            if (cmdWrite && wrState_reg == ST_IDLE) begin
                refArm_reg <= 1'b1;
                refCnt_reg <= 5'h00;
                refAt_reg <= (mr0_reg[1:0] == dmb_pkg::BL_FIX4) ?
                             wl + dmb_pkg::BURST_CK - dmb_pkg::BC4_PULL :
                             wl + dmb_pkg::BURST_CK;
            end else if (refArm_reg && ckRise) begin
                refCnt_reg <= refCnt_reg + 5'h01;
                if (refCnt_reg + 5'h01 == refAt_reg) begin
                    wrRefPulse <= 1'b1;
                    refArm_reg <= 1'b0;
                end
            end
        end
    end

    // register port: write address and data taken together
    assign wrEn = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wrEn;
    assign s_axi_wready = wrEn;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dllCyc_reg <= dmb_pkg::DLLCYC_RESET;
        end else if (wrEn && s_axi_awaddr == dmb_pkg::ADDR_DLLCYC) begin
            if (s_axi_wstrb[0]) begin
                dllCyc_reg[7:0] <= s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
                dllCyc_reg[15:8] <= s_axi_wdata[15:8];
            end
        end
    end
    // read-only registers accept writes silently; unmapped answers decode error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dmb_pkg::RESP_OKAY;
        end else if (wrEn) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr[7:4] == 4'h0 && s_axi_awaddr[1:0] == 2'h0) ?
                           dmb_pkg::RESP_OKAY : dmb_pkg::RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    assign statusWord = {27'h000_0000, testMode, dllFrozen,
                         wrState_reg != ST_IDLE, rdState_reg != ST_IDLE, dllLocking};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dmb_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= dmb_pkg::RESP_OKAY;
            case (s_axi_araddr)
                dmb_pkg::ADDR_MR0: s_axi_rdata <= {18'h0_0000, mr0_reg};
                dmb_pkg::ADDR_MR1: s_axi_rdata <= {18'h0_0000, mr1_reg};
                dmb_pkg::ADDR_STATUS: s_axi_rdata <= statusWord;
                dmb_pkg::ADDR_DLLCYC: s_axi_rdata <= {16'h0000, dllCyc_reg};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= dmb_pkg::RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> dmb_ctrl_model.sv
`timescale 1ns/1ns
// Purpose: controller model driving link clock, command and address pins
// Assumes: link clock runs free at 125 ns
// Notes: released bank and address pins show the inverse of their last value; command pins return high
module dmb_ctrl_model (
    output logic ckPin,
    output logic ckeIn,
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic [2:0] baIn,
    output logic [13:0] addrIn
);
    time tCmd = 0;
    initial begin
        ckPin = 1'b0;
        ckeIn = 1'b1;
        csN = 1'b1;
        {rasN, casN, weN} = 3'h7;
        baIn = 3'h0;
        addrIn = 14'h0000;
    end
    always begin
        #62;
        ckPin = 1'b1;
        #63;
        ckPin = 1'b0;
    end
    task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] a);
        @(negedge ckPin);
        csN = 1'b0;
        {rasN, casN, weN} = rcw;
        baIn = ba;
        addrIn = a;
        @(posedge ckPin);
        tCmd = $time;
        @(negedge ckPin);
        csN = 1'b1;
        {rasN, casN, weN} = 3'h7;
        baIn = ~ba;
        addrIn = ~a;
    endtask
    // reserved bit and test mode always written low
    task automatic mrs(input logic [2:0] ba, input logic [13:0] a);
        cmd(3'h0, ba, a & 14'h1F7F);
    endtask
    task automatic cke(input logic v);
        @(negedge ckPin);
        ckeIn = v;
    endtask
endmodule

// >>> dmb_mode_burst_chk.sv
`timescale 1ns/1ns
// Purpose: port checks for dmb_mode_burst
// Assumes: one clk domain
// Notes: beat timing is judged by the bench
module dmb_mode_burst_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic rdBeatValid,
    input wire logic dqOe,
    input wire logic dqsOe,
    input wire logic wrBeatValid,
    input wire logic wrRefPulse,
    input wire logic [5:0] dalCycles
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_tail_float: assert property (dqOe |-> rdBeatValid)
        else $error("driver on outside a beat");
    a_strobe_pair: assert property (dqOe == dqsOe)
        else $error("strobe and data enables differ");
    a_rd_hold: assert property ($rose(rdBeatValid) |-> rdBeatValid [*5])
        else $error("read beat too short");
    a_wr_hold: assert property ($rose(wrBeatValid) |-> wrBeatValid [*5])
        else $error("write beat too short");
    a_ref_single: assert property (wrRefPulse |=> !wrRefPulse)
        else $error("reference pulse too long");
    a_dal_range: assert property (dalCycles >= 6'h10 && dalCycles <= 6'h1B)
        else $error("precharge delay out of range");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        |=> s_axi_bvalid) else $error("write not answered");
    a_rd_decerr: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 8'h0C
        |=> s_axi_rvalid && s_axi_rresp == dmb_pkg::RESP_DECERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    c_read: cover property ($rose(rdBeatValid));
    c_ref: cover property (wrRefPulse);
    c_decerr: cover property (s_axi_rvalid && s_axi_rresp == dmb_pkg::RESP_DECERR);
endmodule
bind dmb_mode_burst dmb_mode_burst_chk dmb_mode_burst_chk_inst (.*);

// >>> test_dmb_mode_burst.sv
`timescale 1ns/1ns
// Purpose: self-checking bench for dmb_mode_burst
// Assumes: dmb_ctrl_model drives the link pins
// Notes: a beat is logged when its column changes
module test_dmb_mode_burst;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ckPin, ckeIn, csN, rasN, casN, weN;
    logic [2:0] baIn;
    logic [13:0] addrIn;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, q;
    logic [2:0] rdColOut, wrColOut, rdC, wrC;
    logic rdBeatValid, dqOe, dqsOe, wrBeatValid, wrRefPulse, dllLocking, dllFrozen, testMode;
    logic rdV, wrV;
    logic lockSeen = 1'b0;
    logic [5:0] dalCycles;
    logic [2:0] rdQ[$];
    logic [2:0] wrQ[$];
    time tRd, tRef;
    int refN, errorCnt = 0, nTests = 0;
    logic [13:0] mrs0[5] = '{14'h0010, 14'h0028, 14'h0012, 14'h0019, 14'h0000};
    logic [2:0] sts[5] = '{3'h1, 3'h5, 3'h6, 3'h3, 3'h2};
    int rls[5] = '{5, 6, 5, 9, 5};
    int rfs[3] = '{9, 9, 7};
    dmb_mode_burst dmb_mode_burst_inst (.*);
    dmb_ctrl_model dmb_ctrl_model_inst (.*);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (rdBeatValid && (!rdV || rdColOut != rdC)) begin
            if (rdQ.size() == 0) tRd = $time;
            rdQ.push_back(rdColOut);
        end
        if (wrBeatValid && (!wrV || wrColOut != wrC)) wrQ.push_back(wrColOut);
        if (wrRefPulse) begin
            refN++;
            tRef = $time;
        end
        if (dllLocking) lockSeen = 1'b1;
        {rdV, rdC, wrV, wrC} = {rdBeatValid, rdColOut, wrBeatValid, wrColOut};
    end
    task automatic testDone;
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one request at a time; payload held until its ready edge
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wr, wr, !wr};
        do begin
            @(posedge clk);
            k++;
        end while (!(wr ? s_axi_awready && s_axi_wready : s_axi_arready) && k < 50);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
        do begin
            @(posedge clk);
            k++;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && k < 50);
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        if (k >= 50) begin
            errorCnt++;
            testDone();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        axi(1'b0, dmb_pkg::ADDR_DLLCYC, 32'h0000_0000);
        chk("dll cycles reset", {16'h0000, dmb_pkg::DLLCYC_RESET}, q);
        axi(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped read", 1, {r, q} === {dmb_pkg::RESP_DECERR, 32'h0000_0000});
        axi(1'b1, 8'h14, 32'h0000_0001);
        chk("unmapped write", dmb_pkg::RESP_DECERR, r);
        axi(1'b1, dmb_pkg::ADDR_DLLCYC, 32'h0000_0004);
        axi(1'b1, dmb_pkg::ADDR_MR0, 32'h0000_1FFF);
        axi(1'b0, dmb_pkg::ADDR_MR0, 32'h0000_0000);
        chk("mode reg read only", 32'h0000_0000, q);
        dmb_ctrl_model_inst.mrs(3'h0, 14'h0110);
        repeat (60) @(posedge clk);
        axi(1'b0, dmb_pkg::ADDR_MR0, 32'h0000_0000);
        chk("dll reset cleared", 32'h0000_0010, q);
        chk("dll lock seen", 32'h0000_0001, lockSeen);
        for (int c = 0; c < 5; c++) begin
            dmb_ctrl_model_inst.mrs(3'h0, mrs0[c]);
            dmb_ctrl_model_inst.mrs(3'h1, c == 3 ? 14'h1008 : 14'h0000);
            rdQ.delete();
            dmb_ctrl_model_inst.cmd(3'h5, 3'h0, {1'b0, c != 3, 9'h000, sts[c]});
            repeat (220) @(posedge clk);
            chk("read beats", (c == 2 || c == 3) ? 4 : 8, rdQ.size());
            for (int i = 0; i < rdQ.size() && i < 8; i++)
                chk("read column", mrs0[c][3] ? sts[c] ^ i
                    : {sts[c][2] ^ i[2], sts[c][1:0] + i[1:0]}, rdQ[i]);
            chk("read latency", 1, tRd > dmb_ctrl_model_inst.tCmd + rls[c] * 125
                && tRd < dmb_ctrl_model_inst.tCmd + rls[c] * 125 + 80);
        end
        for (int c = 0; c < 3; c++) begin
            dmb_ctrl_model_inst.mrs(3'h0, {12'h004, 2'(c)});
            refN = 0;
            wrQ.delete();
            dmb_ctrl_model_inst.cmd(3'h4, 3'h0, {1'b0, c == 0, 9'h000, 3'h5});
            repeat (220) @(posedge clk);
            for (int i = 0; i < (c == 0 ? 8 : 4); i++)
                chk("write column", c == 0 ? i : 4 + i, wrQ[i]);
            chk("ref pulses", 1, refN);
            chk("ref time", 1, tRef > dmb_ctrl_model_inst.tCmd + rfs[c] * 125
                && tRef < dmb_ctrl_model_inst.tCmd + rfs[c] * 125 + 80);
        end
        dmb_ctrl_model_inst.mrs(3'h0, 14'h0010);
        dmb_ctrl_model_inst.cke(1'b0);
        repeat (50) @(posedge clk);
        chk("dll frozen", 1, dllFrozen);
        dmb_ctrl_model_inst.cke(1'b1);
        dmb_ctrl_model_inst.mrs(3'h0, 14'h1010);
        dmb_ctrl_model_inst.cke(1'b0);
        repeat (50) @(posedge clk);
        chk("dll kept", 0, dllFrozen);
        chk("test mode off", 0, testMode);
        testDone();
    end
endmodule
